/* rtl/bpg_pkg.sv */
// Package for the burst pulse generator: field widths, config bit positions, timing constants, carriers.
// Assumes a single 20 MHz system clock that stands in for the fast oscillator clock.
package bpg_pkg;
  // Clock
  localparam int unsigned SYS_CLK_HZ         = 20_000_000;
  localparam int unsigned SYS_PERIOD_NS      = 1_000_000_000 / SYS_CLK_HZ;

  // Field widths
  localparam int unsigned COUNT_W            = 7;
  localparam int unsigned MASK_W             = 16;
  localparam int unsigned LIMIT_W            = 7;
  localparam int unsigned LFSR_W             = 8;

  // Burst limits
  localparam logic [6:0]  MASK_MAX_PULSES    = 7'h0F;
  localparam logic [6:0]  COUNT_OFF          = 7'h00;

  // Output configuration bit positions inside the 3-bit field (word bits 31, 30, 29)
  localparam int unsigned CFG_BOTH_BIT       = 2;
  localparam int unsigned CFG_UP_BIT         = 1;
  localparam int unsigned CFG_DOWN_BIT       = 0;

  // LFSR reset seed and feedback taps
  localparam logic [7:0]  LFSR_SEED          = 8'hA5;
  localparam logic [7:0]  LFSR_TAPS          = 8'hB8;

  // Step timer accumulates two units per clock, so the step rate is twice the base rate over (fire divide + 1)
  localparam logic [6:0]  STEP_INC           = 7'h02;

  typedef enum logic [1:0] {
    BPG_IDLE,
    BPG_JITTER,
    BPG_RUN
  } bpg_state_t;

  // Static burst configuration as it arrives on the ports
  typedef struct packed {
    logic [6:0]  pulse_count;
    logic [15:0] phase_mask;
    logic [2:0]  output_config;
    logic        idle_gnd;
    logic        start_internal;
    logic        jitter_off;
    logic [1:0]  hs_div_sel;
    logic [3:0]  fire_div;
  } bpg_cfg_t;

  // Complete state of the generator
  typedef struct packed {
    bpg_state_t  st;
    logic [6:0]  cnt;
    logic [6:0]  idx;
    logic        half;
    logic [1:0]  jit;
    logic [7:0]  lfsr;
    logic        alt;
    logic        use_up;
    logic        use_dn;
    logic        both;
    logic        up;
    logic        up_oe;
    logic        dn;
    logic        dn_oe;
    logic        tdc_start;
    logic        busy;
  } bpg_core_t;
endpackage

/* rtl/bpg_step_timer.sv */
// Step clock timer: fractional divider producing one-cycle step ticks.
// Assumes limit is at least 2; the owner holds clr high while no burst runs.
`timescale 1ns/10ps
module bpg_step_timer (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  // Control
  input  wire logic       clr_i,
  input  wire logic [6:0] limit_i,
  // Tick
  output logic            tick_o
);
  typedef struct packed {
    logic [6:0] acc;
    logic       tick;
  } bpg_tmr_t;

  bpg_tmr_t q;
  bpg_tmr_t d;
  logic [7:0] sum;

  ////////////////////////////////////////////////////////////////////////
  // Accumulate two units per clock; wrap at limit gives doubled base rate
  always_comb begin
    d = q;
    sum = {1'b0, q.acc} + {1'b0, bpg_pkg::STEP_INC};
    d.tick = 1'b0;
    if (clr_i) begin
      d.acc = 7'h00;
    end else if (sum >= {1'b0, limit_i}) begin
      d.acc  = 7'(sum - {1'b0, limit_i});
      d.tick = 1'b1;
    end else begin
      d.acc = sum[6:0];
    end
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_o = q.tick;
endmodule

/* rtl/bpg_burst_gen.sv */
// Burst pulse generator top: launches bursts of 1..127 pulses on two transducer drive outputs.
// Assumes synchronous one-cycle launch pulses and configuration held stable during a burst.
//
// Summary of operation
// R1 - Base pulse clock is the fast clock divided by 1, 2 or 4.
// R2 - Step clock is doubled base divided by fire divider plus one; zero forbidden.
// R3 - Exactly the programmed 1..127 pulses per burst; zero count disables generator.
// R4 - Each pulse spends one step period high and one step period low.
// R5 - A flight measure launch starts a burst.
// R6 - With start select set, burst start drives the measuring unit start.
// R7 - Idle outputs float when idle select is zero, drive ground when one.
// R8 - Phase mask applies only for bursts of 15 or fewer; mask bit 15 kept clear.
// R9 - Mask bit zero gives high-then-low, one gives low-then-high.
// R10 - Mask bit zero shapes the first pulse, higher bits later pulses.
// R11 - Two outputs each separately floatable; second may invert the first.
// R12 - Host sets at most one of the three output configuration bits.
// R13 - Both-outputs bit drives both at once, second the inverse of first.
// R14 - Up bit enables first output only; it fires first when alternating.
// R15 - Down bit enables second output only; it fires first when alternating.
// R16 - Phase jitter control adds random start delay to decorrelate averaged results.
// R17 - Host keeps the repeat field zero.
// R18 - Alternating launches swap the firing output on each measurement.
// R19 - After the last pulse enabled outputs return to idle level.
`timescale 1ns/10ps
module bpg_burst_gen (
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_i,
  // Launch commands
  input  wire logic                   launch_flight_measure_i,
  input  wire logic                   launch_alternating_measure_i,
  // Configuration
  input  wire bpg_pkg::bpg_cfg_t      cfg_i,
  // Drive outputs, enable high while driving
  output logic                        fire_up_o,
  output logic                        fire_up_oe_o,
  output logic                        fire_down_o,
  output logic                        fire_down_oe_o,
  // Status and start event
  output logic                        tdc_start_o,
  output logic                        busy_o
);
  bpg_pkg::bpg_core_t q;
  bpg_pkg::bpg_core_t d;
  logic       tick;
  logic [6:0] limit;
  logic [2:0] base_div;
  logic       launch;
  logic       phase_bit;
  logic       level;
  logic       active;
  logic       tmr_clr;

  ////////////////////////////////////////////////////////////////////////
  // Step timer: limit = base divide times (fire divide + 1), counted in half units
  always_comb begin
    case (cfg_i.hs_div_sel) // [R1]
      2'h0:    base_div = 3'h1;
      2'h1:    base_div = 3'h2;
      default: base_div = 3'h4;
    endcase
    limit = 7'(base_div) * (7'(cfg_i.fire_div) + 7'h01); // [R2]
  end

  // Timer starts in the cycle that enters RUN, so the first half is no longer than the rest
  assign tmr_clr = (d.st != bpg_pkg::BPG_RUN); // [R4]

  bpg_step_timer bpg_step_timer_inst (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .clr_i     (tmr_clr),
    .limit_i   (limit),
    .tick_o    (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state and registered output levels
  always_comb begin
    d = q;
    d.tdc_start = 1'b0;
    d.lfsr = {q.lfsr[6:0], ^(q.lfsr & bpg_pkg::LFSR_TAPS)};
    launch = launch_flight_measure_i | launch_alternating_measure_i;
    phase_bit = 1'b0;
    level = 1'b0;
    active = 1'b0;
    case (q.st)
      bpg_pkg::BPG_IDLE: begin
        // A zero count keeps the generator off; launches are then ignored
        if (launch && cfg_i.pulse_count != bpg_pkg::COUNT_OFF) begin // [R3] [R5]
          d.cnt  = cfg_i.pulse_count;
          d.idx  = 7'h00;
          d.half = 1'b0;
          d.both = cfg_i.output_config[bpg_pkg::CFG_BOTH_BIT]; // [R13]
          d.use_up = cfg_i.output_config[bpg_pkg::CFG_UP_BIT]; // [R14]
          d.use_dn = cfg_i.output_config[bpg_pkg::CFG_DOWN_BIT]; // [R15]
          if (launch_alternating_measure_i) begin
            // Swap the single enabled output on every other alternating launch
            d.alt = ~q.alt; // [R18]
            if (q.alt && !d.both) begin
              d.use_up = cfg_i.output_config[bpg_pkg::CFG_DOWN_BIT];
              d.use_dn = cfg_i.output_config[bpg_pkg::CFG_UP_BIT];
            end
          end else begin
            d.alt = 1'b0;
          end
          // Random 0..3 cycle start delay unless jitter is switched off
          d.jit  = cfg_i.jitter_off ? 2'h0 : q.lfsr[1:0]; // [R16]
          d.st   = bpg_pkg::BPG_JITTER;
          d.busy = 1'b1;
        end
      end
      bpg_pkg::BPG_JITTER: begin
        if (q.jit == 2'h0) begin
          d.st = bpg_pkg::BPG_RUN;
          d.tdc_start = cfg_i.start_internal; // [R6]
          active = 1'b1;
          phase_bit = (q.cnt <= bpg_pkg::MASK_MAX_PULSES) ? cfg_i.phase_mask[0] : 1'b0; // [R8] [R10]
          level = ~phase_bit; // [R9]
        end else begin
          d.jit = q.jit - 2'h1;
        end
      end
      bpg_pkg::BPG_RUN: begin
        active = 1'b1;
        // Down-only bursts force the first pin low, so the level lives in the second pin
        level = (q.both | q.use_up) ? q.up : q.dn; // [R15]
        if (tick) begin
          if (!q.half) begin
            // Second step of the pulse inverts the first
            d.half = 1'b1; // [R4]
            phase_bit = (q.cnt <= bpg_pkg::MASK_MAX_PULSES) ? cfg_i.phase_mask[q.idx[3:0]] : 1'b0;
            level = phase_bit;
          end else if (q.idx + 7'h01 == q.cnt) begin
            d.st = bpg_pkg::BPG_IDLE; // [R3]
            d.busy = 1'b0;
            active = 1'b0; // [R19]
          end else begin
            d.idx  = q.idx + 7'h01;
            d.half = 1'b0;
            phase_bit = (q.cnt <= bpg_pkg::MASK_MAX_PULSES) ? cfg_i.phase_mask[4'(q.idx + 7'h01)] : 1'b0;
            level = ~phase_bit; // [R9] [R10]
          end
        end
      end
      default: begin
        d.st = bpg_pkg::BPG_IDLE;
      end
    endcase
    // Output pins: idle level is float or ground, second output may run inverted
    if (active) begin
      d.up    = level;
      d.up_oe = q.both | d.use_up | cfg_i.idle_gnd; // [R11]
      d.dn    = q.both ? ~level : level; // [R13]
      d.dn_oe = q.both | d.use_dn | cfg_i.idle_gnd;
      if (!(q.both | d.use_up)) begin
        d.up = 1'b0;
      end
      if (!(q.both | d.use_dn)) begin
        d.dn = 1'b0;
      end
    end else if (d.st == bpg_pkg::BPG_IDLE || d.st == bpg_pkg::BPG_JITTER) begin
      d.up    = 1'b0; // [R7] [R19]
      d.dn    = 1'b0;
      d.up_oe = cfg_i.idle_gnd;
      d.dn_oe = cfg_i.idle_gnd;
    end
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      q <= '0;
      q.lfsr <= bpg_pkg::LFSR_SEED;
    end else begin
      q <= d;
    end
  end

  assign fire_up_o      = q.up;
  assign fire_up_oe_o   = q.up_oe;
  assign fire_down_o    = q.dn;
  assign fire_down_oe_o = q.dn_oe;
  assign tdc_start_o    = q.tdc_start;
  assign busy_o         = q.busy;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  AST_ZERO_OFF: assert property ((q.st == bpg_pkg::BPG_IDLE && launch && cfg_i.pulse_count == 7'h00) // [R3]
    |=> q.st == bpg_pkg::BPG_IDLE) else $error("zero count launched a burst");
  AST_LAUNCH: assert property ((q.st == bpg_pkg::BPG_IDLE && launch_flight_measure_i // [R5]
    && cfg_i.pulse_count != 7'h00) |=> busy_o ##[1:4] $rose(q.st == bpg_pkg::BPG_RUN))
    else $error("launch did not start a burst");
  AST_START_EVT: assert property ($rose(q.st == bpg_pkg::BPG_RUN) |-> tdc_start_o == cfg_i.start_internal) // [R6]
    else $error("start event mismatch");
  AST_IDLE_LVL: assert property ((q.st == bpg_pkg::BPG_IDLE && !busy_o && $stable(cfg_i.idle_gnd)) // [R7]
    |-> fire_up_oe_o == cfg_i.idle_gnd && !fire_up_o && !fire_down_o) else $error("bad idle level");
  AST_INVERT: assert property ((q.st == bpg_pkg::BPG_RUN && q.both) // [R13]
    |-> fire_down_o == !fire_up_o && fire_down_oe_o) else $error("second output not inverse");
  AST_HALF: assert property ((q.st == bpg_pkg::BPG_RUN && tick && !q.half) // [R4]
    |=> fire_up_o != $past(fire_up_o) || !q.both) else $error("pulse halves not opposite");
  AST_FIRST_PH: assert property (($rose(q.st == bpg_pkg::BPG_RUN) && q.both && q.cnt <= 7'h0F) // [R9]
    |-> fire_up_o == !cfg_i.phase_mask[0]) else $error("first pulse phase wrong");
  AST_UP_ONLY: assert property ((q.st == bpg_pkg::BPG_RUN && q.use_up && !q.both) |-> !fire_down_o) // [R14]
    else $error("second output fired in single mode");
  AST_ALT: assert property ((q.st == bpg_pkg::BPG_IDLE && launch_alternating_measure_i // [R18]
    && !launch_flight_measure_i && cfg_i.pulse_count != 7'h00) |=> q.alt != $past(q.alt))
    else $error("alternation did not toggle");
  AST_END: assert property ($fell(busy_o) |-> !fire_up_o && !fire_down_o) // [R19]
    else $error("not idle after burst");

  // Step alignment, down-only level hold, one-cycle start event and fixed start delay
  AST_STEP_ALIGN: assert property (($rose(q.st == bpg_pkg::BPG_RUN) && limit == 7'h02) |-> tick) // [R4]
    else $error("first step tick late");
  AST_DN_ONLY: assert property ((q.st == bpg_pkg::BPG_RUN && q.use_dn && !q.both) |-> !fire_up_o) // [R15]
    else $error("first output fired in single mode");
  AST_DN_HOLD: assert property ((q.st == bpg_pkg::BPG_RUN && q.use_dn && !q.both && !tick) // [R15]
    |=> $stable(fire_down_o)) else $error("second output level not held between steps");
  AST_TDC_ONE: assert property (tdc_start_o |=> !tdc_start_o) // [R6]
    else $error("start event longer than one cycle");
  AST_NO_JIT: assert property ((q.st == bpg_pkg::BPG_IDLE && launch && cfg_i.pulse_count != 7'h00 // [R16]
    && cfg_i.jitter_off) |=> ##1 q.st == bpg_pkg::BPG_RUN) else $error("fixed start delay not kept");

  COV_BURST: cover property ($fell(busy_o));
  COV_ALT:   cover property (launch_alternating_measure_i && q.st == bpg_pkg::BPG_IDLE && q.alt);
  COV_BOTH:  cover property (q.st == bpg_pkg::BPG_RUN && q.both);
  COV_JIT:   cover property (q.st == bpg_pkg::BPG_JITTER && q.jit == 2'h3);
  COV_DOWN:  cover property (q.st == bpg_pkg::BPG_RUN && q.use_dn && !q.both && !tick);
endmodule

/* testbench/bpg_xducer_model.sv */
// Transducer pair model: counts the pulses that reach each piezo.
// Assumes drive enables are high while the generator drives a pin.
`timescale 1ns/10ps
module bpg_xducer_model (
  // Clock and clear
  input  wire logic       sys_clk_i,
  input  wire logic       clr_i,
  // Drive pins
  input  wire logic       up_i,
  input  wire logic       up_oe_i,
  input  wire logic       dn_i,
  input  wire logic       dn_oe_i,
  // Pulse counts
  output logic [7:0]      up_cnt_o,
  output logic [7:0]      dn_cnt_o
);
  logic up_q;
  logic dn_q;

  // A floating pin reads low through the RC path, so only driven highs count
  always_ff @(posedge sys_clk_i) begin
    up_q <= up_i & up_oe_i;
    dn_q <= dn_i & dn_oe_i;
    if (clr_i) begin
      up_cnt_o <= 8'h00;
      dn_cnt_o <= 8'h00;
    end else begin
      up_cnt_o <= up_cnt_o + 8'((up_i & up_oe_i) & ~up_q);
      dn_cnt_o <= dn_cnt_o + 8'((dn_i & dn_oe_i) & ~dn_q);
    end
  end
endmodule

/* testbench/tb_burst_pulse_generator.sv */
// Self-checking bench for the burst pulse generator.
// Assumes the host keeps divider nonzero, mask bit 15 and repeat field clear.
`timescale 1ns/10ps
module tb_burst_pulse_generator;
  logic              sys_clk;
  logic              reset;
  logic              go_plain;
  logic              go_alt;
  logic              clr;
  bpg_pkg::bpg_cfg_t cfg;
  logic              up;
  logic              up_oe;
  logic              dn;
  logic              dn_oe;
  logic              tdc;
  logic              busy;
  logic [7:0]        up_cnt;
  logic [7:0]        dn_cnt;
  int                fails = 0;
  int                tests_run = 0;

  ////////////////////////////////////////
  // Clock, design and partner
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  bpg_burst_gen bpg_burst_gen_inst (.sys_clk_i(sys_clk), .reset_i(reset), .launch_flight_measure_i(go_plain),
    .launch_alternating_measure_i(go_alt), .cfg_i(cfg), .fire_up_o(up), .fire_up_oe_o(up_oe),
    .fire_down_o(dn), .fire_down_oe_o(dn_oe), .tdc_start_o(tdc), .busy_o(busy));

  bpg_xducer_model bpg_xducer_model_inst (.sys_clk_i(sys_clk), .clr_i(clr), .up_i(up), .up_oe_i(up_oe),
    .dn_i(dn), .dn_oe_i(dn_oe), .up_cnt_o(up_cnt), .dn_cnt_o(dn_cnt));

  ////////////////////////////////////////
  // Compare and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results;
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Config changes only between bursts, at a falling edge; one output bit, no repeat
  task automatic set(input logic [6:0] n, input logic [15:0] ph, input logic [2:0] oc, input logic ig,
                     input logic si, input logic [1:0] hs, input logic [3:0] fd);
    cfg = '{n, ph, oc, ig, si, 1'b1, hs, fd};
  endtask

  // Launch, then judge every cycle until busy drops; sel 0 up, 1 down, 2 both
  task automatic burst(input logic alt, input int n, input int l, input int sel, input logic [15:0] ph);
    int   k;
    int   e;
    logic want;
    k = 0;
    e = 0;
    @(negedge sys_clk);
    if (alt) begin
      go_alt = 1'b1;
    end else begin
      go_plain = 1'b1;
    end
    @(negedge sys_clk);
    go_plain = 1'b0;
    go_alt = 1'b0;
    // First level and the one-cycle start event both stand two falling edges after the launch
    @(negedge sys_clk);
    chk(busy, 1);
    chk(tdc, cfg.start_internal);
    while (busy === 1'b1 && k < 20000) begin
      want = ((k % l) < l / 2) ^ (n <= 15 && ph[k / l]);
      if (((sel == 1) ? dn : up) !== want || ((sel == 1) ? dn_oe : up_oe) !== 1'b1) e++;
      if (sel == 2 && (dn !== ~up || dn_oe !== 1'b1)) e++;
      if (sel == 0 && {dn_oe, dn} !== {cfg.idle_gnd, 1'b0}) e++;
      if (sel == 1 && {up_oe, up} !== {cfg.idle_gnd, 1'b0}) e++;
      k++;
      @(negedge sys_clk);
    end
    chk(k, n * l);
    chk(e, 0);
    chk({up_oe, dn_oe, up, dn}, {cfg.idle_gnd, cfg.idle_gnd, 2'b00});
  endtask

  ////////////////////////////////////////
  // Scenarios
  task automatic t_walk;
    set(7'h01, 16'h0000, 3'b100, 1'b1, 1'b1, 2'h0, 4'h1);
    burst(1'b0, 1, 2, 2, 16'h0000);
  endtask

  task automatic t_phase;
    set(7'h0F, 16'h4A53, 3'b010, 1'b0, 1'b0, 2'h0, 4'h1);
    burst(1'b0, 15, 2, 0, 16'h4A53);
  endtask

  // Above fifteen pulses the mask must be ignored
  task automatic t_long;
    set(7'h7F, 16'h7FFF, 3'b001, 1'b1, 1'b0, 2'h0, 4'h1);
    burst(1'b0, 127, 2, 1, 16'h7FFF);
  endtask

  task automatic t_div;
    logic [1:0] hs[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic [3:0] fd[4] = '{4'h1, 4'hF, 4'h3, 4'h7};
    for (int i = 0; i < 4; i++) begin
      set(7'h02, 16'h0000, 3'b100, 1'b1, 1'b1, hs[i], fd[i]);
      burst(1'b0, 2, ((hs[i] == 0) ? 1 : (hs[i] == 1) ? 2 : 4) * (int'(fd[i]) + 1), 2, 16'h0000);
    end
  endtask

  task automatic t_off;
    set(7'h00, 16'h0000, 3'b100, 1'b1, 1'b1, 2'h0, 4'h1);
    go_plain = 1'b1;
    @(negedge sys_clk);
    go_plain = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk({busy, tdc, up, dn}, 0);
  endtask

  // Alternation swaps outputs; a plain launch restarts it
  task automatic t_alt;
    set(7'h03, 16'h0000, 3'b010, 1'b1, 1'b0, 2'h0, 4'h1);
    burst(1'b1, 3, 2, 0, 16'h0000);
    burst(1'b1, 3, 2, 1, 16'h0000);
    burst(1'b0, 3, 2, 0, 16'h0000);
    burst(1'b1, 3, 2, 0, 16'h0000);
    // Slower step so the down-only level must hold across idle cycles
    set(7'h03, 16'h0000, 3'b001, 1'b1, 1'b0, 2'h0, 4'h3);
    burst(1'b0, 3, 4, 1, 16'h0000);
    burst(1'b1, 3, 4, 1, 16'h0000);
  endtask

  // Random start delay must not change the pulse count
  task automatic t_jit;
    int w;
    set(7'h05, 16'h0000, 3'b100, 1'b1, 1'b1, 2'h0, 4'h1);
    cfg.jitter_off = 1'b0;
    clr = 1'b1;
    @(negedge sys_clk);
    clr = 1'b0;
    go_plain = 1'b1;
    @(negedge sys_clk);
    go_plain = 1'b0;
    w = 0;
    @(negedge sys_clk);
    while (busy === 1'b1 && w < 500) begin
      w++;
      @(negedge sys_clk);
    end
    chk({up_cnt, dn_cnt}, {8'h05, 8'h05});
  endtask

  ////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    reset = 1'b1;
    go_plain = 1'b0;
    go_alt = 1'b0;
    clr = 1'b1;
    cfg = '0;
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    clr = 1'b0;
    t_walk();
    t_phase();
    t_long();
    t_div();
    t_off();
    t_alt();
    t_jit();
    results();
  end

  // Whole run needs under two thousand cycles
  initial begin
    #250000;
    fails++;
    results();
  end
endmodule
